/* File: timer_unit_device.sv */
// Overview of operation
// - Protect bit set loads clock-off config field
// - Protect bit acts at write, reads zero
// - Application reset clears the module enable bit and all config fields
// - Reserved configuration bits read as zero
// - Identification low byte gives module revision
// - Identification high byte gives module type
// - Timer unit runs on system clock
// - Input pins configured with control msb clear
// - Output pins configured with control msb set
// - Interrupt nodes enabled and levelled before service
// - Each of five timers has count input
// - Each of five timers has direction input
// - Each timer drives its own interrupt request
// - Timers b and e drive count outputs
// - Timer e signals overflow/underflow to neighbours
// - Capture input raises capture interrupt request
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module timer_unit_device
    import timer_unit_pkg::*;
#(
    parameter int TW = TIMER_W,
    // Arbitrary identification values
    parameter logic [7:0] IDENT_NUMBER = 8'h3c,
    parameter logic [7:0] REVISION_NUMBER = 8'h07
) (
    input wire logic clk,
    input wire logic arst_n,
    timer_link_if.device link,
    input wire logic suspend_req,
    input wire logic clock_off_req,
    output logic module_running,
    output kernel_mode_e active_mode
);
    kernel_mode_e next_mode;
    logic ksc_write;
    logic module_enable;
    logic [CFG_W-1:0] normal_cfg;
    logic [CFG_W-1:0] suspend_cfg;
    logic [CFG_W-1:0] clock_off_cfg;
    logic [CFG_W-1:0] selected_cfg;
    logic next_running;
    logic [TW-1:0] count_value [NUM_TIMERS];
    logic [NUM_TIMERS-1:0] wrap;
    logic capture_prev;
    logic capture_edge;
    logic [TW-1:0] capture_value;
    logic [DATA_W-1:0] next_rdata;

    assign ksc_write = link.wr && (link.addr == KSC_OFFSET);

    // Clock-off request outranks suspend, which outranks normal running
    always_comb begin
        if (clock_off_req) begin
            next_mode = MODE_CLOCK_OFF;
        end else if (suspend_req) begin
            next_mode = MODE_SUSPEND;
        end else begin
            next_mode = MODE_NORMAL;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            active_mode <= MODE_NORMAL;
        end else begin
            active_mode <= next_mode;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            module_enable <= MODULE_ENABLE_RESET;
        end else if (ksc_write && link.wdata[MODULE_ENABLE_PROTECT_BIT]) begin
            module_enable <= link.wdata[MODULE_ENABLE_BIT];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            normal_cfg <= CFG_RESET;
        end else if (ksc_write && link.wdata[NORMAL_CFG_PROTECT_BIT]) begin
            normal_cfg <= link.wdata[NORMAL_CFG_LSB +: CFG_W];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            suspend_cfg <= CFG_RESET;
        end else if (ksc_write && link.wdata[SUSPEND_CFG_PROTECT_BIT]) begin
            suspend_cfg <= link.wdata[SUSPEND_CFG_LSB +: CFG_W];
        end
    end

    // The protect bit has no storage: it only qualifies this write
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            clock_off_cfg <= CFG_RESET;
        end else if (ksc_write
                && link.wdata[CLOCK_OFF_CFG_WRITE_PROTECT_BIT]) begin
            clock_off_cfg <= link.wdata[CLOCK_OFF_CFG_LSB +: CFG_W];
        end
    end

    always_comb begin
        case (active_mode)
            MODE_NORMAL: begin
                selected_cfg = normal_cfg;
            end
            MODE_SUSPEND: begin
                selected_cfg = suspend_cfg;
            end
            MODE_CLOCK_OFF: begin
                selected_cfg = clock_off_cfg;
            end
            default: begin
                selected_cfg = normal_cfg;
            end
        endcase
    end

    assign next_running = module_enable & ~selected_cfg[CFG_OFF_BIT];

    // Everything runs on clk itself; switching off only freezes counting and capture
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            module_running <= 1'b0;
        end else begin
            module_running <= next_running;
        end
    end

    generate
        for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_timer
            timer_cell #(
                .W(TW)
            ) u_timer (
                .clk(clk),
                .arst_n(arst_n),
                .enable(module_running),
                .count_pin(link.count_in[i]),
                .down(link.dir_in[i]),
                .value(count_value[i]),
                .wrap(wrap[i])
            );
        end
    endgenerate

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            link.irq <= '0;
        end else begin
            link.irq <= wrap;
        end
    end

    // Count outputs toggle on each wrap, giving half the wrap rate
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            link.count_out_b <= 1'b0;
        end else if (wrap[TIMER_B]) begin
            link.count_out_b <= ~link.count_out_b;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            link.count_out_e <= 1'b0;
        end else if (wrap[TIMER_E]) begin
            link.count_out_e <= ~link.count_out_e;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            link.overflow_e <= 1'b0;
        end else begin
            link.overflow_e <= wrap[TIMER_E];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            capture_prev <= 1'b0;
        end else begin
            capture_prev <= link.capture_in;
        end
    end

    assign capture_edge = link.capture_in & ~capture_prev & module_running;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            capture_value <= '0;
        end else if (capture_edge) begin
            capture_value <= count_value[TIMER_D];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            link.capture_irq <= 1'b0;
        end else begin
            link.capture_irq <= capture_edge;
        end
    end

    // Only the configuration register is writable; identification has
    // no write path at all
    always_comb begin
        next_rdata = '0;
        case (link.addr)
            KSC_OFFSET: begin
                next_rdata[MODULE_ENABLE_BIT] = module_enable;
                next_rdata[NORMAL_CFG_LSB +: CFG_W] = normal_cfg;
                next_rdata[SUSPEND_CFG_LSB +: CFG_W] = suspend_cfg;
                next_rdata[CLOCK_OFF_CFG_LSB +: CFG_W] = clock_off_cfg;
            end
            ID_OFFSET: begin
                next_rdata[REVISION_LSB +: 8] = REVISION_NUMBER;
                next_rdata[IDENT_LSB +: 8] = IDENT_NUMBER;
            end
            CAPTURE_OFFSET: begin
                next_rdata = DATA_W'(capture_value);
            end
            STATUS_OFFSET: begin
                next_rdata[STATUS_RUNNING_BIT] = module_running;
                next_rdata[STATUS_MODE_LSB +: 3] = active_mode;
            end
            default: begin
                for (int i = 0; i < NUM_TIMERS; i++) begin
                    if (link.addr == COUNT_BASE + COUNT_STEP * 16'(i)) begin
                        next_rdata = DATA_W'(count_value[i]);
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            link.rdata <= '0;
        end else if (link.rd) begin
            link.rdata <= next_rdata;
        end else begin
            link.rdata <= '0;
        end
    end

endmodule : timer_unit_device

`default_nettype wire

/* File: timer_unit_pkg.sv */
package timer_unit_pkg;

    localparam int DATA_W = 16;
    localparam int ADDR_W = 16;
    localparam int NUM_TIMERS = 5;
    localparam int TIMER_W = 16;
    localparam int NUM_INPUT_PINS = 11;
    localparam int NUM_NODES = 6;
    localparam int LEVEL_W = 4;

    // Register byte addresses
    localparam logic [15:0] KSC_OFFSET = 16'hfe1c;
    localparam logic [15:0] ID_OFFSET = 16'hffe6;
    localparam logic [15:0] COUNT_BASE = 16'hfe40;
    localparam logic [15:0] COUNT_STEP = 16'h0002;
    localparam logic [15:0] CAPTURE_OFFSET = 16'hfe4a;
    localparam logic [15:0] STATUS_OFFSET = 16'hfe4c;

    // Kernel state configuration field positions
    localparam int MODULE_ENABLE_BIT = 0;
    localparam int MODULE_ENABLE_PROTECT_BIT = 1;
    localparam int NORMAL_CFG_LSB = 4;
    localparam int NORMAL_CFG_PROTECT_BIT = 7;
    localparam int SUSPEND_CFG_LSB = 8;
    localparam int SUSPEND_CFG_PROTECT_BIT = 11;
    localparam int CLOCK_OFF_CFG_LSB = 12;
    localparam int CLOCK_OFF_CFG_WRITE_PROTECT_BIT = 15;
    localparam int CFG_W = 2;
    localparam int CFG_OFF_BIT = 1;

    // Identification field positions
    localparam int REVISION_LSB = 0;
    localparam int IDENT_LSB = 8;

    // Status register field positions
    localparam int STATUS_RUNNING_BIT = 0;
    localparam int STATUS_MODE_LSB = 1;

    // Reset values
    localparam logic MODULE_ENABLE_RESET = 1'b0;
    localparam logic [1:0] CFG_RESET = 2'b00;
    localparam logic [15:0] TIMER_RESET = 16'h0000;

    // Timer slots with extra outputs or capture, and the capture node
    localparam int TIMER_B = 1;
    localparam int TIMER_D = 3;
    localparam int TIMER_E = 4;
    localparam int CAPTURE_NODE = 5;

    typedef enum logic [2:0] {
        MODE_NORMAL = 3'b001,
        MODE_SUSPEND = 3'b010,
        MODE_CLOCK_OFF = 3'b100
    } kernel_mode_e;

endpackage : timer_unit_pkg

/* File: timer_link_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface timer_link_if;
    import timer_unit_pkg::*;

    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
    logic [DATA_W-1:0] rdata;
    logic [NUM_TIMERS-1:0] count_in;
    logic [NUM_TIMERS-1:0] dir_in;
    logic capture_in;
    logic [NUM_TIMERS-1:0] irq;
    logic capture_irq;
    logic count_out_b;
    logic count_out_e;
    logic overflow_e;

    modport device (
        input addr, wdata, wr, rd, count_in, dir_in, capture_in,
        output rdata, irq, capture_irq, count_out_b, count_out_e,
        output overflow_e
    );

    modport host (
        output addr, wdata, wr, rd, count_in, dir_in, capture_in,
        input rdata, irq, capture_irq, count_out_b, count_out_e,
        input overflow_e
    );

endinterface : timer_link_if

`default_nettype wire

/* File: timer_cell.sv */
`timescale 1ns/1ps
`default_nettype none

module timer_cell #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic enable,
    input wire logic count_pin,
    input wire logic down,
    output logic [W-1:0] value,
    output logic wrap
);
    logic count_prev;
    logic count_edge;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count_prev <= 1'b0;
        end else begin
            count_prev <= count_pin;
        end
    end

    assign count_edge = count_pin & ~count_prev;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            value <= '0;
        end else if (enable && count_edge) begin
            value <= down ? value - 1'b1 : value + 1'b1;
        end
    end

    // Wrap pulse marks overflow going up or underflow going down
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wrap <= 1'b0;
        end else begin
            wrap <= enable && count_edge && (down ? (value == '0) : (&value));
        end
    end

endmodule : timer_cell

`default_nettype wire

/* File: timer_unit_host.sv */
`timescale 1ns/1ps
`default_nettype none

module timer_unit_host
    import timer_unit_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    timer_link_if.host link,
    input wire logic [ADDR_W-1:0] cmd_addr,
    input wire logic [DATA_W-1:0] cmd_wdata,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    output logic [DATA_W-1:0] cmd_rdata,
    output logic cmd_rvalid,
    input wire logic [NUM_TIMERS-1:0] count_pin,
    input wire logic [NUM_TIMERS-1:0] direction_pin,
    input wire logic capture_pin,
    input wire logic [NUM_INPUT_PINS-1:0] input_pin_ctrl_msb,
    input wire logic [1:0] output_pin_ctrl_msb,
    output logic [1:0] count_out_pin,
    input wire logic [NUM_NODES-1:0] node_enable,
    input wire logic [NUM_NODES-1:0][LEVEL_W-1:0] node_level,
    input wire logic [NUM_NODES-1:0] irq_clear,
    output logic [NUM_NODES-1:0] irq_pending,
    output logic service_request,
    output logic overflow_seen
);
    logic rd_issued;
    logic [NUM_NODES-1:0] node_ready;
    logic [NUM_NODES-1:0] node_source;
    logic [NUM_NODES-1:0] next_pending;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            link.addr <= '0;
            link.wdata <= '0;
            link.wr <= 1'b0;
            link.rd <= 1'b0;
        end else begin
            link.addr <= cmd_addr;
            link.wdata <= cmd_wdata;
            link.wr <= cmd_wr;
            link.rd <= cmd_rd;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_issued <= 1'b0;
            cmd_rvalid <= 1'b0;
            cmd_rdata <= '0;
        end else begin
            rd_issued <= link.rd;
            cmd_rvalid <= rd_issued;
            cmd_rdata <= rd_issued ? link.rdata : '0;
        end
    end

    // A pin set up as output never feeds a timer input
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            link.count_in <= '0;
            link.dir_in <= '0;
            link.capture_in <= 1'b0;
        end else begin
            link.count_in <= count_pin
                & ~input_pin_ctrl_msb[NUM_TIMERS-1:0];
            link.dir_in <= direction_pin
                & ~input_pin_ctrl_msb[2*NUM_TIMERS-1:NUM_TIMERS];
            link.capture_in <= capture_pin
                & ~input_pin_ctrl_msb[2*NUM_TIMERS];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count_out_pin <= '0;
        end else begin
            count_out_pin <= {link.count_out_e, link.count_out_b}
                & output_pin_ctrl_msb;
        end
    end

    // Level zero means the node has not been programmed yet
    always_comb begin
        for (int i = 0; i < NUM_NODES; i++) begin
            node_ready[i] = node_enable[i] && (node_level[i] != '0);
        end
    end

    assign node_source = {link.capture_irq, link.irq};
    // A request in the clearing cycle still sets the flag
    assign next_pending = (irq_pending & ~irq_clear)
        | (node_source & node_ready);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_pending <= '0;
            service_request <= 1'b0;
        end else begin
            irq_pending <= next_pending;
            service_request <= |next_pending;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            overflow_seen <= 1'b0;
        end else begin
            overflow_seen <= link.overflow_e;
        end
    end

endmodule : timer_unit_host

`default_nettype wire

/* File: timer_unit_props.sv */
`timescale 1ns/1ps
`default_nettype none

module timer_unit_props
    import timer_unit_pkg::*;
#(
    parameter logic [7:0] IDENT_NUMBER = 8'h3c,
    parameter logic [7:0] REVISION_NUMBER = 8'h07
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic [NUM_TIMERS-1:0] count_in,
    input wire logic [NUM_TIMERS-1:0] dir_in,
    input wire logic capture_in,
    input wire logic [NUM_TIMERS-1:0] irq,
    input wire logic capture_irq,
    input wire logic count_out_b,
    input wire logic count_out_e,
    input wire logic overflow_e
);
    logic ksc_rd;
    logic id_rd;
    logic [CFG_W-1:0] off_cfg;
    logic [3:0][NUM_TIMERS:0] hist;
    logic [NUM_TIMERS:0] recent;

    assign ksc_rd = rd && addr == KSC_OFFSET;
    assign id_rd = rd && addr == ID_OFFSET;
    assign recent = hist[0] | hist[1] | hist[2] | hist[3];

    // Reference copy of the clock-off field, loaded only under protection
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            off_cfg <= CFG_RESET;
        end else if (wr && addr == KSC_OFFSET
                     && wdata[CLOCK_OFF_CFG_WRITE_PROTECT_BIT]) begin
            off_cfg <= wdata[CLOCK_OFF_CFG_LSB +: CFG_W];
        end
    end

    // Pin activity of the last four cycles; events may lag by that much
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hist <= '0;
        end else begin
            hist <= {hist[2:0], capture_in, count_in};
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_off_cfg;
        ksc_rd |=> rdata[13:12] == $past(off_cfg);
    endproperty
    a_off_cfg: assert property (p_off_cfg)
        else $error("clock-off field differs from protected writes");
    property p_prot_zero;
        ksc_rd |=> !rdata[15] && !rdata[11] && !rdata[7] && !rdata[1];
    endproperty
    a_prot_zero: assert property (p_prot_zero)
        else $error("protection bit read as one");
    property p_resv_zero;
        ksc_rd |=> rdata[3:2] == 2'b00 && !rdata[6] && !rdata[10]
            && !rdata[14];
    endproperty
    a_resv_zero: assert property (p_resv_zero)
        else $error("reserved bit read as one");
    property p_revision;
        id_rd |=> rdata[7:0] == REVISION_NUMBER;
    endproperty
    a_revision: assert property (p_revision)
        else $error("revision field wrong");
    property p_ident;
        id_rd |=> rdata[15:8] == IDENT_NUMBER;
    endproperty
    a_ident: assert property (p_ident)
        else $error("identification field wrong");
    property p_rdata_idle;
        !rd |=> rdata == '0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside its cycle");
    property p_irq_pulse;
        irq != '0 |=> (irq & $past(irq)) == '0;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("timer request longer than one cycle");
    property p_out_b;
        $changed(count_out_b) |-> recent[TIMER_B];
    endproperty
    a_out_b: assert property (p_out_b)
        else $error("count output b toggled without a count");
    property p_out_e;
        $changed(count_out_e) |-> recent[TIMER_E];
    endproperty
    a_out_e: assert property (p_out_e)
        else $error("count output e toggled without a count");
    property p_overflow;
        overflow_e |-> recent[TIMER_E] ##1 !overflow_e;
    endproperty
    a_overflow: assert property (p_overflow)
        else $error("overflow event without timer e count");
    property p_capture;
        capture_irq |-> recent[NUM_TIMERS] ##1 !capture_irq;
    endproperty
    a_capture: assert property (p_capture)
        else $error("capture request without capture input");

    c_off_write: cover property (wr && addr == KSC_OFFSET && wdata[15]);
    c_down_wrap: cover property (dir_in[0] && irq[0]);
    c_capture: cover property (capture_irq);
    c_id_read: cover property (id_rd);
endmodule : timer_unit_props

`default_nettype wire

/* File: timer_unit_id_and_interface_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module timer_unit_id_and_interface_tb;
    import timer_unit_pkg::*;
    // Arbitrary identification values
    localparam logic [7:0] IDN = 8'h3c;
    localparam logic [7:0] REV = 8'h07;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic suspend_req = 1'b0;
    logic clock_off_req = 1'b0;
    logic module_running;
    kernel_mode_e active_mode;
    logic [ADDR_W-1:0] cmd_addr = '0;
    logic [DATA_W-1:0] cmd_wdata = '0;
    logic cmd_wr = 1'b0;
    logic cmd_rd = 1'b0;
    logic [DATA_W-1:0] cmd_rdata;
    logic cmd_rvalid;
    logic [NUM_TIMERS-1:0] count_pin = '0;
    logic [NUM_TIMERS-1:0] direction_pin = '1;
    logic capture_pin = 1'b0;
    logic [NUM_INPUT_PINS-1:0] input_pin_ctrl_msb = '0;
    logic [1:0] output_pin_ctrl_msb = 2'b11;
    logic [1:0] count_out_pin;
    logic [NUM_NODES-1:0] node_enable = '1;
    logic [NUM_NODES-1:0][LEVEL_W-1:0] node_level = {NUM_NODES{4'h1}};
    logic [NUM_NODES-1:0] irq_clear = '0;
    logic [NUM_NODES-1:0] irq_pending;
    logic service_request;
    logic overflow_seen;
    int n_mismatch = 0;
    int samples_checked = 0;
    int ovf_count = 0;

    always #2 clk = ~clk;
    always @(posedge clk) if (overflow_seen === 1'b1) ovf_count++;

    timer_link_if link ();
    // Short timers so that a wrap takes a handful of counts
    timer_unit_device #(.TW(4), .IDENT_NUMBER(IDN), .REVISION_NUMBER(REV))
    i_timer_unit_device (.clk(clk), .arst_n(arst_n), .link(link),
        .suspend_req(suspend_req), .clock_off_req(clock_off_req),
        .module_running(module_running), .active_mode(active_mode));
    timer_unit_host i_timer_unit_host (.clk(clk), .arst_n(arst_n),
        .link(link), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata),
        .cmd_rvalid(cmd_rvalid), .count_pin(count_pin),
        .direction_pin(direction_pin), .capture_pin(capture_pin),
        .input_pin_ctrl_msb(input_pin_ctrl_msb),
        .output_pin_ctrl_msb(output_pin_ctrl_msb),
        .count_out_pin(count_out_pin), .node_enable(node_enable),
        .node_level(node_level), .irq_clear(irq_clear),
        .irq_pending(irq_pending), .service_request(service_request),
        .overflow_seen(overflow_seen));
    timer_unit_props #(.IDENT_NUMBER(IDN), .REVISION_NUMBER(REV))
    i_timer_unit_props (.clk(clk), .arst_n(arst_n), .addr(link.addr),
        .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata),
        .count_in(link.count_in), .dir_in(link.dir_in),
        .capture_in(link.capture_in), .irq(link.irq),
        .capture_irq(link.capture_irq), .count_out_b(link.count_out_b),
        .count_out_e(link.count_out_e), .overflow_e(link.overflow_e));

    task automatic finish_test();
        $display("compared %0d mismatched %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr_reg(logic [15:0] a, logic [15:0] d);
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_wr <= 1'b1;
        @(posedge clk);
        cmd_wr <= 1'b0;
        @(posedge clk);
    endtask : wr_reg

    task automatic rd_reg(logic [15:0] a, logic [15:0] exp);
        bit got;
        got = 1'b0;
        cmd_addr <= a;
        cmd_rd <= 1'b1;
        @(posedge clk);
        cmd_rd <= 1'b0;
        for (int i = 0; i < 8 && !got; i++) begin
            @(posedge clk);
            got = (cmd_rvalid === 1'b1);
        end
        if (!got) begin
            n_mismatch++;
            finish_test();
        end else begin
            check($sformatf("register %h", a), cmd_rdata, exp);
        end
    endtask : rd_reg

    // Pins stay low between pulses so every count is a fresh edge
    task automatic pulse(logic [4:0] m);
        count_pin <= m;
        @(posedge clk);
        count_pin <= '0;
        repeat (6) @(posedge clk);
    endtask : pulse

    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rd_reg(KSC_OFFSET, 16'h0000);
        wr_reg(KSC_OFFSET, 16'h0003);
        rd_reg(KSC_OFFSET, 16'h0001);
        rd_reg(ID_OFFSET, {IDN, REV});
        wr_reg(ID_OFFSET, 16'h0000);
        rd_reg(ID_OFFSET, {IDN, REV});
        rd_reg(16'h0000, 16'h0000);
        wr_reg(KSC_OFFSET, 16'h3000);
        rd_reg(KSC_OFFSET, 16'h0001);
        wr_reg(KSC_OFFSET, 16'hd00d);
        rd_reg(KSC_OFFSET, 16'h1001);
        rd_reg(STATUS_OFFSET, 16'h0003);
        suspend_req <= 1'b1;
        repeat (2) @(posedge clk);
        rd_reg(STATUS_OFFSET, 16'h0005);
        suspend_req <= 1'b0;
        clock_off_req <= 1'b1;
        repeat (2) @(posedge clk);
        rd_reg(STATUS_OFFSET, 16'h0009);
        wr_reg(KSC_OFFSET, 16'ha000);
        rd_reg(KSC_OFFSET, 16'h2001);
        rd_reg(STATUS_OFFSET, 16'h0008);
        check("running", {15'h0, module_running}, 16'h0000);
        check("mode", {13'h0, active_mode}, {13'h0, MODE_CLOCK_OFF});
        wr_reg(KSC_OFFSET, 16'h9000);
        wr_reg(KSC_OFFSET, 16'h2001);
        rd_reg(KSC_OFFSET, 16'h1001);
        clock_off_req <= 1'b0;
        repeat (2) @(posedge clk);
        check("running", {15'h0, module_running}, 16'h0001);
        pulse(5'h1f);
        for (int i = 0; i < NUM_TIMERS; i++) begin
            rd_reg(COUNT_BASE + 16'(2 * i), 16'h000f);
        end
        check("pending", {10'h0, irq_pending}, 16'h001f);
        check("count out", {14'h0, count_out_pin}, 16'h0003);
        check("overflow", 16'(ovf_count), 16'h0001);
        capture_pin <= 1'b1;
        @(posedge clk);
        capture_pin <= 1'b0;
        repeat (6) @(posedge clk);
        rd_reg(CAPTURE_OFFSET, 16'h000f);
        check("pending", {10'h0, irq_pending}, 16'h003f);
        check("service", {15'h0, service_request}, 16'h0001);
        irq_clear <= '1;
        @(posedge clk);
        irq_clear <= '0;
        repeat (2) @(posedge clk);
        check("pending", {10'h0, irq_pending}, 16'h0000);
        direction_pin <= '0;
        node_enable <= 6'h3d;
        pulse(5'h03);
        check("pending", {10'h0, irq_pending}, 16'h0001);
        check("count out", {14'h0, count_out_pin}, 16'h0002);
        output_pin_ctrl_msb <= 2'b01;
        repeat (2) @(posedge clk);
        check("count out", {14'h0, count_out_pin}, 16'h0000);
        output_pin_ctrl_msb <= 2'b11;
        input_pin_ctrl_msb <= 11'h001;
        pulse(5'h01);
        rd_reg(COUNT_BASE, 16'h0000);
        input_pin_ctrl_msb <= '0;
        pulse(5'h01);
        rd_reg(COUNT_BASE, 16'h0001);
        rd_reg(COUNT_BASE + COUNT_STEP, 16'h0000);
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rd_reg(KSC_OFFSET, 16'h0000);
        check("pending", {10'h0, irq_pending}, 16'h0000);
        finish_test();
    end
endmodule : timer_unit_id_and_interface_tb

`default_nettype wire
